// file: core/rwt_timer.sv
// reload wave timer: prescaler, 8-bit auto-reload counter, four pwm channels, two captures
// What this block does
// - 8-bit up-counter advances on each prescaler tick
// - overflow reloads counter; prescaler keeps running
// - software reads and overwrites live counter
// - prescaler divides by two to divider_select
// - clock_source_select picks cpu or external clock
// - counter_run_enable low freezes prescaler and counter
// - reset clears counter, prescaler, control register
// - force_reload or counter write clears prescaler
// - hidden compare copied from duty only at overflow
// - wave_pin_enable hands pin to pwm signal
// - overflow drives output to polarity level
// - compare match returns output to idle level
// - period is 256 minus reload value
// - overflow sets flag and gated interrupt request
// - external events also counted toward overflow
// - capture edge copies counter and sets flag
// - per channel edge select and interrupt enable
// - capture blocked until capture_value read clears
// - capture interrupt stays while flag and enable
// - halt stops pwm; capture interrupt still wakes
// - status read clears overflow flag; enable writable
// - edge select zero falling, one rising
`default_nettype none
module rwt_timer
	import rwt_pkg::*;
#(
	parameter int NUM_WAVE = 4
) (
	// clock and reset
	input  wire logic                clock_in,
	input  wire logic                resetn_in,
	// classic wishbone slave
	input  wire logic                wb_cyc_in,
	input  wire logic                wb_stb_in,
	input  wire logic                wb_we_in,
	input  wire logic [5:0]          wb_adr_in,
	input  wire logic [3:0]          wb_sel_in,
	input  wire logic [31:0]         wb_dat_in,
	output logic      [31:0]         wb_dat_out,
	output logic                     wb_ack_out,
	// external pins
	input  wire logic                ext_clock_in,
	input  wire logic [1:0]          capture_pin_in,
	output logic      [NUM_WAVE-1:0] wave_output_pin_out,
	output logic      [NUM_WAVE-1:0] wave_output_pin_oen_out,
	// interrupt requests and wake
	output logic                     overflow_irq_out,
	output logic      [1:0]          capture_irq_out,
	output logic                     wake_out
);

	typedef struct packed {
		logic [1:0]            ext_sync;
		logic                  ext_prev;
		logic [1:0][1:0]       cap_sync;
		logic [1:0]            cap_prev;
		logic [6:0]            presc;
		logic [7:0]            count;
		logic [7:0]            reload;
		logic [7:0]            ctrl;
		logic [7:0]            wave_ctrl;
		logic [3:0][7:0]       duty;
		logic [3:0][7:0]       cmp;
		logic [3:0]            phase;
		logic [1:0]            edge_sel;
		logic [1:0]            cap_ien;
		logic [1:0]            cap_flag;
		logic [1:0][7:0]       cap_val;
		logic                  halt;
		logic                  ack;
		logic [31:0]           rdata;
	} rwt_state_t;

	rwt_state_t s_q;
	rwt_state_t s_d;

	// does prescaler tap n fire, given the counter of input ticks before increment
	function automatic logic rwt_tap_fires(input logic [6:0] pre, input logic [2:0] sel);
		logic [7:0] mask;
		mask = 8'(({1'b0, 7'h7F} >> (3'd7 - sel)));
		rwt_tap_fires = ((8'({1'b0, pre}) & mask) == mask);
	endfunction : rwt_tap_fires

	logic       in_tick;
	logic       cnt_tick;
	logic       ovf;
	logic       acc;
	logic       wr;
	logic       rd;
	logic [1:0] cap_edge;
	logic [7:0] wbyte;

	// bus decode; one-cycle wait then ack, dropped the cycle after
	assign acc   = wb_cyc_in && wb_stb_in && !s_q.ack;
	assign wr    = acc && wb_we_in && wb_sel_in[0];
	assign rd    = acc && !wb_we_in;
	assign wbyte = wb_dat_in[7:0];

	// input clock source, external edges taken after two flops
	assign in_tick = s_q.ctrl[RWT_CSR_RUN] && !s_q.halt &&
		(s_q.ctrl[RWT_CSR_SRC] ? (s_q.ext_sync[1] && !s_q.ext_prev) : 1'b1);
	assign cnt_tick = in_tick && rwt_tap_fires(s_q.presc, s_q.ctrl[RWT_CSR_DIVHI:RWT_CSR_DIVLO]);
	assign ovf      = cnt_tick && (s_q.count == RWT_CNT_TOP);

	// capture edges per channel, chosen polarity
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			cap_edge[i] = s_q.edge_sel[i] ? (s_q.cap_sync[i][1] && !s_q.cap_prev[i])
				: (!s_q.cap_sync[i][1] && s_q.cap_prev[i]);
		end
	end

	// next state of all registers
	always_comb begin
		s_d = s_q;
		s_d.ext_sync = {s_q.ext_sync[0], ext_clock_in};
		s_d.ext_prev = s_q.ext_sync[1];
		for (int i = 0; i < 2; i++) begin
			s_d.cap_sync[i] = {s_q.cap_sync[i][0], capture_pin_in[i]};
			s_d.cap_prev[i] = s_q.cap_sync[i][1];
		end
		s_d.ack = acc;
		// prescaler runs freely through overflow
		if (in_tick) begin
			s_d.presc = 7'(s_q.presc + 7'h01);
		end
		// counter advance and reload
		if (ovf) begin
			s_d.count = s_q.reload;
			s_d.ctrl[RWT_CSR_OVF] = 1'b1;
			s_d.cmp = s_q.duty;
			s_d.phase = '1;
		end else if (cnt_tick) begin
			s_d.count = 8'(s_q.count + 8'h01);
		end
		// compare match ends active phase until next overflow
		for (int i = 0; i < NUM_WAVE; i++) begin
			if (!ovf && cnt_tick && (8'(s_q.count + 8'h01) == s_q.cmp[i])) begin
				s_d.phase[i] = 1'b0;
			end
		end
		// captures blocked while flag stands
		for (int i = 0; i < 2; i++) begin
			if (rd && wb_adr_in == (i == 0 ? RWT_OFF_CAP1 : RWT_OFF_CAP2)) begin
				s_d.cap_flag[i] = 1'b0;
			end
			if (cap_edge[i] && !s_q.cap_flag[i]) begin
				s_d.cap_val[i] = s_q.count;
				s_d.cap_flag[i] = 1'b1;                                                  // set wins over read clear
			end
		end
		// overflow flag cleared by status read, unless it sets now
		if (rd && wb_adr_in == RWT_OFF_CSR && !ovf) begin
			s_d.ctrl[RWT_CSR_OVF] = 1'b0;
		end
		// register writes
		if (wr) begin
			unique case (wb_adr_in)
				RWT_OFF_DUTY0, RWT_OFF_DUTY1, RWT_OFF_DUTY2, RWT_OFF_DUTY3: begin
					s_d.duty[wb_adr_in[3:2]] = wbyte;
				end
				RWT_OFF_WAVE:   s_d.wave_ctrl = wbyte;
				RWT_OFF_CSR: begin
					s_d.ctrl[7:1] = {wbyte[7:3], 1'b0, wbyte[RWT_CSR_OIE]};
					if (wbyte[RWT_CSR_FRL]) begin
						s_d.count = s_q.reload;
						s_d.presc = RWT_RST_PRE;
					end
				end
				RWT_OFF_CNT: begin
					s_d.count = wbyte;
					s_d.presc = RWT_RST_PRE;
				end
				RWT_OFF_RELOAD: s_d.reload = wbyte;
				RWT_OFF_CAPCSR: begin
					s_d.edge_sel = wbyte[5:4];
					s_d.cap_ien  = wbyte[3:2];
				end
				RWT_OFF_HALT:   s_d.halt = wbyte[0];
				default: begin
				end
			endcase
		end
		// read data, unmapped reads answer zero
		s_d.rdata = 32'h0000_0000;
		if (rd) begin
			unique case (wb_adr_in)
				RWT_OFF_DUTY0, RWT_OFF_DUTY1, RWT_OFF_DUTY2, RWT_OFF_DUTY3: begin
					s_d.rdata[7:0] = s_q.duty[wb_adr_in[3:2]];
				end
				RWT_OFF_WAVE:   s_d.rdata[7:0] = s_q.wave_ctrl;
				RWT_OFF_CSR:    s_d.rdata[7:0] = s_q.ctrl;
				RWT_OFF_CNT:    s_d.rdata[7:0] = s_q.count;
				RWT_OFF_RELOAD: s_d.rdata[7:0] = s_q.reload;
				RWT_OFF_CAPCSR: s_d.rdata[7:0] = {2'b00, s_q.edge_sel, s_q.cap_ien, s_q.cap_flag};
				RWT_OFF_CAP1:   s_d.rdata[7:0] = s_q.cap_val[0];
				RWT_OFF_CAP2:   s_d.rdata[7:0] = s_q.cap_val[1];
				RWT_OFF_HALT:   s_d.rdata[7:0] = {7'h00, s_q.halt};
				default: begin
				end
			endcase
		end
	end

	// single state register; reset takes constants only
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs; polarity applied live so a change flips the pin at once
	always_comb begin
		for (int i = 0; i < NUM_WAVE; i++) begin
			wave_output_pin_out[i] = (s_q.phase[i] && !s_q.halt) ^ s_q.wave_ctrl[i];
			wave_output_pin_oen_out[i] = !s_q.wave_ctrl[4 + i];
		end
	end
	assign wb_ack_out       = s_q.ack;
	assign wb_dat_out       = s_q.rdata;
	assign overflow_irq_out = s_q.ctrl[RWT_CSR_OVF] && s_q.ctrl[RWT_CSR_OIE];
	assign capture_irq_out  = s_q.cap_flag & s_q.cap_ien;
	assign wake_out         = s_q.halt && (|(s_q.cap_flag & s_q.cap_ien));

	// checks beside the logic
	sequence rwt_top_tick_s;
		cnt_tick && s_q.count == RWT_CNT_TOP;
	endsequence

	AST_RELOAD: assert property (@(posedge clock_in) disable iff (!resetn_in)
		rwt_top_tick_s and !wr |=> s_q.count == $past(s_q.reload)) else $error("no reload on overflow");
	AST_OVF_SET: assert property (@(posedge clock_in) disable iff (!resetn_in)
		rwt_top_tick_s |=> s_q.ctrl[RWT_CSR_OVF]) else $error("overflow flag not set");
	AST_FREEZE: assert property (@(posedge clock_in) disable iff (!resetn_in)
		!s_q.ctrl[RWT_CSR_RUN] && !wr |=> $stable(s_q.count) && $stable(s_q.presc)) else $error("frozen timer moved");
	AST_CMP_COPY: assert property (@(posedge clock_in) disable iff (!resetn_in)
		!ovf |=> $stable(s_q.cmp)) else $error("compare changed off overflow");
	AST_CNT_WR: assert property (@(posedge clock_in) disable iff (!resetn_in)
		wr && wb_adr_in == RWT_OFF_CNT |=> s_q.presc == RWT_RST_PRE && s_q.count == $past(wbyte))
		else $error("counter write failed");
	AST_CAP_HOLD: assert property (@(posedge clock_in) disable iff (!resetn_in)
		s_q.cap_flag[0] |=> $stable(s_q.cap_val[0])) else $error("capture overwritten");
	AST_CAP_IRQ: assert property (@(posedge clock_in) disable iff (!resetn_in)
		s_q.cap_flag[1] && s_q.cap_ien[1] |-> capture_irq_out[1]) else $error("capture irq dropped");
	AST_OVF_CLR: assert property (@(posedge clock_in) disable iff (!resetn_in)
		rd && wb_adr_in == RWT_OFF_CSR && !ovf |=> !s_q.ctrl[RWT_CSR_OVF] ##1 !wb_ack_out)
		else $error("status read did not clear");
	AST_DIV1: assert property (@(posedge clock_in) disable iff (!resetn_in)
		in_tick && s_q.ctrl[6:4] == 3'h0 |-> cnt_tick) else $error("divide by one missed");

	// a plain tick moves the counter by exactly one
	AST_CNT_STEP: assert property (@(posedge clock_in) disable iff (!resetn_in)
		cnt_tick && !ovf && !wr |=> s_q.count == 8'($past(s_q.count) + 8'h01))
		else $error("counter did not step");

	// the reload must not disturb the prescaler phase
	AST_PRESC_RUN: assert property (@(posedge clock_in) disable iff (!resetn_in)
		rwt_top_tick_s and !wr |=> s_q.presc == 7'($past(s_q.presc) + 7'h01))
		else $error("prescaler disturbed by overflow");

	// software sees the live count one cycle after the take
	AST_CNT_READ: assert property (@(posedge clock_in) disable iff (!resetn_in)
		rd && wb_adr_in == RWT_OFF_CNT |=> wb_dat_out == {24'h000000, $past(s_q.count)})
		else $error("counter read wrong");

	// divide by two fires on every odd prescaler value
	AST_DIV2: assert property (@(posedge clock_in) disable iff (!resetn_in)
		in_tick && s_q.ctrl[6:4] == 3'h1 |-> cnt_tick == s_q.presc[0])
		else $error("divide by two tap wrong");

	// external source: no tick without a synchronised rising edge
	AST_EXT_GATE: assert property (@(posedge clock_in) disable iff (!resetn_in)
		s_q.ctrl[RWT_CSR_SRC] && !(s_q.ext_sync[1] && !s_q.ext_prev) |-> !cnt_tick)
		else $error("tick without external edge");

	// held in reset, the timer state reads zero
	AST_RESET_CLEAR: assert property (@(posedge clock_in)
		!resetn_in |-> s_q.count == 8'h00 && s_q.presc == RWT_RST_PRE && s_q.ctrl == RWT_RST_BYTE)
		else $error("reset state not clear");

	// force reload takes the reload value and restarts the prescaler
	AST_FRL_LOAD: assert property (@(posedge clock_in) disable iff (!resetn_in)
		wr && wb_adr_in == RWT_OFF_CSR && wbyte[RWT_CSR_FRL] |=> s_q.presc == RWT_RST_PRE && s_q.count == $past(s_q.reload))
		else $error("force reload failed");

	// compare values follow the duty buffers at overflow
	AST_CMP_LOAD: assert property (@(posedge clock_in) disable iff (!resetn_in)
		rwt_top_tick_s |=> s_q.cmp == $past(s_q.duty))
		else $error("compare not loaded at overflow");

	// an enabled channel drives its pin
	AST_PIN_GIVEN: assert property (@(posedge clock_in) disable iff (!resetn_in)
		s_q.wave_ctrl[4] |-> !wave_output_pin_oen_out[0])
		else $error("enabled pin not driven");

	// after overflow the pin shows the active level
	AST_OVF_LEVEL: assert property (@(posedge clock_in) disable iff (!resetn_in)
		rwt_top_tick_s |=> s_q.halt || wave_output_pin_out[0] != s_q.wave_ctrl[0])
		else $error("pin not active after overflow");

	// reaching the compare value returns the pin to idle
	AST_MATCH_IDLE: assert property (@(posedge clock_in) disable iff (!resetn_in)
		cnt_tick && !ovf && 8'(s_q.count + 8'h01) == s_q.cmp[0] |=> !s_q.phase[0])
		else $error("match did not end pulse");

	// enabled overflow raises the request the next cycle
	AST_OVF_IRQ: assert property (@(posedge clock_in) disable iff (!resetn_in)
		rwt_top_tick_s and (s_q.ctrl[RWT_CSR_OIE] && !wr) |=> overflow_irq_out)
		else $error("overflow request missing");

	// each external event advances the counter at divide by one
	AST_EVENT_TICK: assert property (@(posedge clock_in) disable iff (!resetn_in)
		s_q.ctrl[RWT_CSR_SRC] && s_q.ctrl[RWT_CSR_RUN] && !s_q.halt &&
		s_q.ext_sync[1] && !s_q.ext_prev && s_q.ctrl[6:4] == 3'h0 |-> cnt_tick)
		else $error("external event lost");

	// an accepted edge latches the count and raises the flag
	AST_CAP_TAKE: assert property (@(posedge clock_in) disable iff (!resetn_in)
		cap_edge[0] && !s_q.cap_flag[0] |=> s_q.cap_flag[0] && s_q.cap_val[0] == $past(s_q.count))
		else $error("capture not taken");

	// channel one keeps its own falling edge choice
	AST_EDGE_CH1: assert property (@(posedge clock_in) disable iff (!resetn_in)
		!s_q.edge_sel[1] && !s_q.cap_sync[1][1] && s_q.cap_prev[1] |-> cap_edge[1])
		else $error("channel one edge missed");

	// reading the capture value frees the channel
	AST_CAP_RDCLR: assert property (@(posedge clock_in) disable iff (!resetn_in)
		rd && wb_adr_in == RWT_OFF_CAP1 && !cap_edge[0] |=> !s_q.cap_flag[0])
		else $error("capture read did not clear");

	// in halt the pin sits at its idle level
	AST_HALT_PWM: assert property (@(posedge clock_in) disable iff (!resetn_in)
		s_q.halt |-> wave_output_pin_out[0] == s_q.wave_ctrl[0])
		else $error("pwm running in halt");

	// a pending capture request wakes the core from halt
	AST_WAKE: assert property (@(posedge clock_in) disable iff (!resetn_in)
		s_q.halt && capture_irq_out[0] |-> wake_out)
		else $error("no wake on capture");

	// rising selection on channel zero sees a rising pin
	AST_RISE_CH0: assert property (@(posedge clock_in) disable iff (!resetn_in)
		s_q.edge_sel[0] && s_q.cap_sync[0][1] && !s_q.cap_prev[0] |-> cap_edge[0])
		else $error("rising edge missed");

	// the second stage lags the pin by two edges
	AST_SYNC: assert property (@(posedge clock_in) disable iff (!resetn_in)
		s_q.ext_sync[1] == $past(ext_clock_in, 2))
		else $error("external synchroniser skewed");

endmodule : rwt_timer
`default_nettype wire

// file: inc/rwt_pkg.sv
// package of register offsets, field positions and reset values for the reload wave timer
`default_nettype none
package rwt_pkg;
	// register byte offsets on the wishbone slave (word aligned)
	localparam logic [5:0] RWT_OFF_DUTY0   = 6'h00;
	localparam logic [5:0] RWT_OFF_DUTY1   = 6'h04;
	localparam logic [5:0] RWT_OFF_DUTY2   = 6'h08;
	localparam logic [5:0] RWT_OFF_DUTY3   = 6'h0C;
	localparam logic [5:0] RWT_OFF_WAVE    = 6'h10;
	localparam logic [5:0] RWT_OFF_CSR     = 6'h14;
	localparam logic [5:0] RWT_OFF_CNT     = 6'h18;
	localparam logic [5:0] RWT_OFF_RELOAD  = 6'h1C;
	localparam logic [5:0] RWT_OFF_CAPCSR  = 6'h20;
	localparam logic [5:0] RWT_OFF_CAP1    = 6'h24;
	localparam logic [5:0] RWT_OFF_CAP2    = 6'h28;
	localparam logic [5:0] RWT_OFF_HALT    = 6'h2C;
	// counter_control_status field positions
	localparam int RWT_CSR_SRC   = 7;
	localparam int RWT_CSR_DIVHI = 6;
	localparam int RWT_CSR_DIVLO = 4;
	localparam int RWT_CSR_RUN   = 3;
	localparam int RWT_CSR_FRL   = 2;
	localparam int RWT_CSR_OIE   = 1;
	localparam int RWT_CSR_OVF   = 0;
	// capture_control_status field positions
	localparam int RWT_CAP_EDGE  = 4;
	localparam int RWT_CAP_IEN   = 2;
	localparam int RWT_CAP_FLAG  = 0;
	// values after reset, and the counter top value
	localparam logic [7:0] RWT_RST_BYTE = 8'h00;
	localparam logic [6:0] RWT_RST_PRE  = 7'h00;
	localparam logic [7:0] RWT_CNT_TOP  = 8'hFF;
endpackage : rwt_pkg
`default_nettype wire

// file: bench/rwt_pin_partner.sv
// pin-side partner: external event clock and capture pins
`default_nettype none
module rwt_pin_partner (
	// pins toward the timer
	input  wire logic       clock_in,
	output logic            ext_clock_out,
	output logic [1:0]      capture_pin_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// pins idle low, the clock stands still between bursts
	initial begin
		ext_clock_out = 1'b0;
		capture_pin_out = 2'b00;
	end
	// slow pulses so the two-flop synchroniser never misses a level
	task automatic events(input int n);
		repeat (n) begin
			repeat (4) @(posedge clock_in);
			ext_clock_out <= 1'b1;
			repeat (4) @(posedge clock_in);
			ext_clock_out <= 1'b0;
		end
	endtask : events
	// one transition on a capture pin
	task automatic flip(input int ch);
		@(posedge clock_in);
		capture_pin_out[ch] <= ~capture_pin_out[ch];
	endtask : flip
endmodule : rwt_pin_partner
`default_nettype wire

// file: bench/rwt_timer_tb_top.sv
// self-checking bench: register traffic, pwm period, overflow, events, capture
`default_nettype none
module rwt_timer_tb_top
	import rwt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock_in = 1'b0;
	logic        resetn_in = 1'b0;
	logic        wb_cyc, wb_stb, wb_we, wb_ack, ext_clk, ovf_irq, wake;
	logic [5:0]  wb_adr;
	logic [3:0]  wb_sel, wave, wave_oen;
	logic [31:0] wb_dat, wb_rdat, rd;
	logic [1:0]  cap_pin, cap_irq;
	int          mismatches = 0;
	int          checks_done = 0;
	int          t, r, hi, per;
	logic [5:0]  offs [7] = '{RWT_OFF_CSR, RWT_OFF_CNT, RWT_OFF_WAVE, RWT_OFF_CAPCSR,
		RWT_OFF_RELOAD, RWT_OFF_CAP1, 6'h30};
	always #10 clock_in = ~clock_in;
	rwt_timer i_rwt_timer (.clock_in(clock_in), .resetn_in(resetn_in), .wb_cyc_in(wb_cyc),
		.wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
		.wb_dat_in(wb_dat), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack), .ext_clock_in(ext_clk),
		.capture_pin_in(cap_pin), .wave_output_pin_out(wave), .wave_output_pin_oen_out(wave_oen),
		.overflow_irq_out(ovf_irq), .capture_irq_out(cap_irq), .wake_out(wake));
	rwt_pin_partner i_rwt_pin_partner (.clock_in(clock_in), .ext_clock_out(ext_clk),
		.capture_pin_out(cap_pin));
	// verdict and end of run
	task automatic results();
		$display("mismatches %0d checks %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// classic single cycle; a missing ack ends the run
	task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clock_in);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_dat <= {24'h000000, d};
		do begin
			@(posedge clock_in);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		if (wb_ack !== 1'b1) begin
			mismatches++;
			results();
		end
	endtask : wb
	// period and high time of pin 0 between its second and third rise
	task automatic measure();
		logic prev;
		prev = wave[0];
		t = 0;
		r = 0;
		hi = 0;
		per = 0;
		while (r < 3 && t < 2000) begin
			@(posedge clock_in);
			t++;
			if (r == 2) begin
				per++;
				if (wave[0] === 1'b1) hi++;
			end
			if (wave[0] === 1'b1 && prev === 1'b0) r++;
			prev = wave[0];
		end
		if (r < 3) begin
			mismatches++;
			results();
		end
	endtask : measure
	initial begin
		{wb_cyc, wb_stb, wb_we} = 3'b000;
		wb_adr = 6'h00;
		wb_sel = 4'h1;
		wb_dat = 32'h00000000;
		repeat (5) @(posedge clock_in);
		resetn_in <= 1'b1;
		foreach (offs[i]) begin
			wb(0, offs[i], 8'h00);
			chk("reset reg", 32'h0, rd);
		end
		chk("oen", 4'hF, wave_oen);
		wb(1, RWT_OFF_CNT, 8'h37);
		repeat (20) @(posedge clock_in);
		wb(0, RWT_OFF_CNT, 8'h00);
		chk("frozen count", 32'h37, rd);
		wb(1, RWT_OFF_RELOAD, 8'hFC);
		wb(1, RWT_OFF_DUTY0, 8'hFE);
		wb(1, RWT_OFF_WAVE, 8'h10);
		chk("oen0", 4'hE, wave_oen);
		for (int n = 0; n < 3; n++) begin
			wb(1, RWT_OFF_CSR, {1'b0, n[2:0], 4'hC});
			measure();
			chk("pwm period", (32'd256 - 32'hFC) << n, per);
			chk("pwm high", (32'hFE - 32'hFC) << n, hi);
		end
		// overflow flag, request and clear on status read
		wb(1, RWT_OFF_CSR, 8'h0A);
		repeat (10) @(posedge clock_in);
		chk("ovf irq", 32'h1, ovf_irq);
		wb(1, RWT_OFF_CSR, 8'h02);
		wb(0, RWT_OFF_CSR, 8'h00);
		chk("status read", 32'h03, rd);
		wb(0, RWT_OFF_CSR, 8'h00);
		chk("status cleared", 32'h02, rd);
		chk("ovf irq off", 32'h0, ovf_irq);
		// three external events to overflow
		wb(1, RWT_OFF_RELOAD, 8'hFD);
		wb(1, RWT_OFF_CSR, 8'h8C);
		i_rwt_pin_partner.events(2);
		wb(0, RWT_OFF_CSR, 8'h00);
		chk("two events", 32'h88, rd);
		i_rwt_pin_partner.events(1);
		wb(0, RWT_OFF_CSR, 8'h00);
		chk("third event", 32'h89, rd);
		wb(1, RWT_OFF_CSR, 8'h80);
		// captures in halt: ch0 rising, ch1 falling, both enabled
		wb(1, RWT_OFF_CAPCSR, 8'h1C);
		wb(1, RWT_OFF_HALT, 8'h01);
		i_rwt_pin_partner.flip(0);
		repeat (5) @(posedge clock_in);
		chk("cap irq 0", 32'h1, cap_irq);
		chk("wake", 32'h1, wake);
		chk("halt pwm", 32'h0, wave[0]);
		wb(1, RWT_OFF_CNT, 8'h40);
		i_rwt_pin_partner.flip(1);
		i_rwt_pin_partner.flip(0);
		i_rwt_pin_partner.flip(0);
		repeat (5) @(posedge clock_in);
		chk("blocked", 32'h1, cap_irq);
		i_rwt_pin_partner.flip(1);
		repeat (5) @(posedge clock_in);
		chk("cap irq both", 32'h3, cap_irq);
		wb(0, RWT_OFF_CAP1, 8'h00);
		chk("cap1 held", 32'hFD, rd);
		wb(0, RWT_OFF_CAP2, 8'h00);
		chk("cap2", 32'h40, rd);
		chk("cap irq cleared", 32'h0, cap_irq);
		i_rwt_pin_partner.flip(0);
		i_rwt_pin_partner.flip(0);
		repeat (5) @(posedge clock_in);
		wb(0, RWT_OFF_CAP1, 8'h00);
		chk("cap1 new", 32'h40, rd);
		wb(1, RWT_OFF_HALT, 8'h00);
		results();
	end
endmodule : rwt_timer_tb_top
`default_nettype wire
